// >>> rtl/ccs_defs.svh
/*
 Offsets, field positions, reset values and write masks of the page-0
 status and identity bank. Assumes byte-wide registers, 8-bit offsets.
*/
// Contract
// - Page select sits at offset 0x01 in every page; read or write it.
// - Page select uses all eight bits, giving 256 pages.
// - Read-only four-digit part number over two bytes, one digit per nibble.
// - Read-only eight-bit grade code, 0 to 3 meaning A to D.
// - Read-only eight-bit revision code, 0 meaning A, counting upward.
// - Writable three-byte tool version with special, revision, minor, major, tool.
// - Writable seven-bit bus address at 6:0, excluded from the burn image.
// - Live fault bits: calibrating, crystal no signal, no reference, lock, timeout.
// - Timeout bit rises on bus timeout only while the port is in I2C mode.
// - Live per-input signal loss in 3:0 and frequency fault in 7:4.
// - Live PLL unlock in 1:0 and holdover in 5:4.
// - Live PLL calibration busy in 5:4, PLL A on bit 4.
// - Sticky copy of each fault bit; software writes 0 to clear.
// - Sticky per-input loss and frequency flags, same mapping as live.
// - Sticky PLL unlock and holdover flags in their own register.
// - One mask bit per sticky flag; a set mask blocks the alarm.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ==========================================================
// Offsets
`define CCS_OFS_PAGE        8'h01
`define CCS_OFS_PN_LO       8'h02
`define CCS_OFS_PN_HI       8'h03
`define CCS_OFS_GRADE       8'h04
`define CCS_OFS_REV         8'h05
`define CCS_OFS_TOOL0       8'h06
`define CCS_OFS_TOOL1       8'h07
`define CCS_OFS_TOOL2       8'h08
`define CCS_OFS_TEMP        8'h09
`define CCS_OFS_PKG         8'h0A
`define CCS_OFS_ADDR        8'h0B
`define CCS_OFS_FLT         8'h0C
`define CCS_OFS_INALM       8'h0D
`define CCS_OFS_LOLHOLD     8'h0E
`define CCS_OFS_CAL         8'h0F
`define CCS_OFS_FLT_STK     8'h11
`define CCS_OFS_INALM_STK   8'h12
`define CCS_OFS_LOLHOLD_STK 8'h13
`define CCS_OFS_CAL_STK     8'h14
`define CCS_OFS_FLT_MSK     8'h17
`define CCS_OFS_INALM_MSK   8'h18
`define CCS_OFS_LOLHOLD_MSK 8'h19
`define CCS_OFS_CAL_MSK     8'h1A

// ==========================================================
// Field positions
`define CCS_FLT_CAL_BIT     0
`define CCS_FLT_XNOSIG_BIT  1
`define CCS_FLT_REFMISS_BIT 2
`define CCS_FLT_XLOCK_BIT   3
`define CCS_FLT_TMOUT_BIT   5

// ==========================================================
// Reset values and implemented bits
`define CCS_PAGE_RST        8'h00
`define CCS_PAGE_ZERO       8'h00
`define CCS_TOOL_RST        24'h000000
`define CCS_ADDR_RST        7'h68
`define CCS_FLT_MSK_RST     8'hC0
`define CCS_MSK_RST         8'h00
`define CCS_FLT_VALID       8'h2F
`define CCS_INALM_VALID     8'hFF
`define CCS_LOLHOLD_VALID   8'h33
`define CCS_CAL_VALID       8'h30
`define CCS_FLT_MSK_VALID   8'hEF

`endif

// >>> rtl/ccs_pkg.sv
/*
 Types of the page-0 status and identity bank.
 Assumes the serial port front end delivers one byte access per request.
*/
package ccs_pkg;

    // ======================================================
    // One register access from the serial port front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccs_req_type;

    // ======================================================
    // Live conditions reported by the analog core
    typedef struct packed {
        logic       dev_cal;
        logic       xtal_nosig;
        logic       ref_missing;
        logic       xtal_lock_fault;
        logic       bus_timeout;
        logic [3:0] in_freq_off;
        logic [3:0] in_sig_missing;
        logic [1:0] pll_holdover;
        logic [1:0] pll_unlocked;
        logic [1:0] pll_cal_busy;
    } ccs_status_type;

    // ======================================================
    // Tool version, most significant field first
    typedef struct packed {
        logic [2:0] tool;
        logic [3:0] major;
        logic [8:0] minor;
        logic [3:0] revision;
        logic [3:0] special;
    } ccs_tool_version_type;

endpackage : ccs_pkg

// >>> rtl/ccs_sync.sv
/*
 Two-stage synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no word coherence is promised.
*/
module ccs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // ccs_sync

// >>> rtl/ccs_sticky.sv
/*
 Byte-laned sticky flags: a live level sets, a written 0 clears.
 Assumes live levels are already on this clock.
*/
module ccs_sticky #(
    parameter int                 LANES = 4,
    parameter logic [LANES*8-1:0] VALID = '1
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // Live conditions and software clear
    input  wire logic [LANES*8-1:0] live,
    input  wire logic [LANES-1:0]   lane_we,
    input  wire logic [7:0]         wdata,
    // Flags
    output logic      [LANES*8-1:0] flags
);
    logic [LANES*8-1:0] clr;
    logic [LANES*8-1:0] next_flags;

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign clr[i*8 +: 8] = lane_we[i] ? ~wdata : 8'h00;
    end
    // Set wins over clear
    assign next_flags = ((flags & ~clr) | live) & VALID;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) flags <= '0;
        else        flags <= next_flags;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_set_wins_clear: assert property (
        (live[0] && lane_we[0] && !wdata[0]) |=> flags[0])
        else $error("set lost to clear on flag 0");
    a_flag_holds: assert property (
        (flags != '0 && lane_we == '0) |=> ((flags & $past(flags)) ==
            $past(flags)))
        else $error("sticky flag dropped without a clear");
    a_zero_clears: assert property (
        (lane_we[0] && !wdata[0] && !live[0]) |=> !flags[0])
        else $error("written 0 did not clear flag 0");
endmodule // ccs_sticky

// >>> rtl/ccs_regs.sv
/*
 Page-0 status and identity register bank of the dual-PLL clock chip.
 Assumes the serial port front end (I2C or SPI) issues byte accesses on
 this clock and that live conditions arrive asynchronously.
*/
`include "ccs_defs.svh"

module ccs_regs
    import ccs_pkg::*;
#(
    // Identity values, all arbitrary
    parameter logic [15:0] PART_NUMBER = 16'h1234,
    parameter logic [7:0]  GRADE_CODE  = 8'h00,
    parameter logic [7:0]  REV_CODE    = 8'h00,
    parameter logic [7:0]  TEMP_CODE   = 8'h00,
    parameter logic [7:0]  PKG_CODE    = 8'h00
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // Register access
    input  wire ccs_req_type          reg_req,
    output logic [7:0]                rd_data,
    output logic                      rd_valid,
    // Live conditions
    input  wire ccs_status_type       status_raw,
    input  wire logic                 i2c_mode,
    // Configuration and alarm outputs
    output logic [7:0]                page_select,
    output logic [6:0]                serial_bus_address,
    output ccs_tool_version_type      tool_version,
    output logic                      fault_alarm,
    // Burn image port
    input  wire logic [7:0]           nvm_addr,
    output logic [7:0]                nvm_data
);
    // ======================================================
    // Synchronised live conditions
    ccs_status_type status_sync;
    logic [7:0]     live_fault;
    logic [7:0]     live_inalm;
    logic [7:0]     live_lolhold;
    logic [7:0]     live_cal;

    ccs_sync #(
        .WIDTH    ($bits(ccs_status_type))
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (status_raw),
        .sync_out (status_sync)
    );

    // Reserved positions tie to zero
    assign live_fault[`CCS_FLT_CAL_BIT]     = status_sync.dev_cal;
    assign live_fault[`CCS_FLT_XNOSIG_BIT]  = status_sync.xtal_nosig;
    assign live_fault[`CCS_FLT_REFMISS_BIT] = status_sync.ref_missing;
    assign live_fault[`CCS_FLT_XLOCK_BIT]   = status_sync.xtal_lock_fault;
    assign live_fault[4]                    = 1'b0;
    // Timeouts only mean anything on the I2C flavour of the port
    assign live_fault[`CCS_FLT_TMOUT_BIT]   =
        status_sync.bus_timeout & i2c_mode;
    assign live_fault[7:6]                  = 2'h0;

    assign live_inalm   = {status_sync.in_freq_off,
                           status_sync.in_sig_missing};
    assign live_lolhold = {2'h0, status_sync.pll_holdover,
                           2'h0, status_sync.pll_unlocked};
    assign live_cal     = {2'h0, status_sync.pll_cal_busy, 4'h0};

    // ======================================================
    // Access decode
    logic       page0;
    logic       wr_page;
    logic       wr_tool0;
    logic       wr_tool1;
    logic       wr_tool2;
    logic       wr_addr;
    logic [3:0] wr_stk;
    logic [3:0] wr_msk;
    logic       wr_p0;

    // Everything it reads comes in as an argument, so assigns track it
    function automatic logic hit(input logic en, input logic [7:0] a,
                                 input logic [7:0] ofs);
        return en && a == ofs;
    endfunction

    assign page0    = page_select == `CCS_PAGE_ZERO;
    assign wr_p0    = reg_req.wr && page0;
    // Page select is reachable from every page
    assign wr_page  = reg_req.wr && reg_req.addr == `CCS_OFS_PAGE;
    assign wr_tool0 = hit(wr_p0, reg_req.addr, `CCS_OFS_TOOL0);
    assign wr_tool1 = hit(wr_p0, reg_req.addr, `CCS_OFS_TOOL1);
    assign wr_tool2 = hit(wr_p0, reg_req.addr, `CCS_OFS_TOOL2);
    assign wr_addr  = hit(wr_p0, reg_req.addr, `CCS_OFS_ADDR);
    assign wr_stk   = {hit(wr_p0, reg_req.addr, `CCS_OFS_CAL_STK),
                       hit(wr_p0, reg_req.addr, `CCS_OFS_LOLHOLD_STK),
                       hit(wr_p0, reg_req.addr, `CCS_OFS_INALM_STK),
                       hit(wr_p0, reg_req.addr, `CCS_OFS_FLT_STK)};
    assign wr_msk   = {hit(wr_p0, reg_req.addr, `CCS_OFS_CAL_MSK),
                       hit(wr_p0, reg_req.addr, `CCS_OFS_LOLHOLD_MSK),
                       hit(wr_p0, reg_req.addr, `CCS_OFS_INALM_MSK),
                       hit(wr_p0, reg_req.addr, `CCS_OFS_FLT_MSK)};

    // ======================================================
    // Sticky flags
    logic [31:0] sticky;

    ccs_sticky #(
        .LANES   (4),
        .VALID   ({`CCS_CAL_VALID, `CCS_LOLHOLD_VALID,
                   `CCS_INALM_VALID, `CCS_FLT_VALID})
    ) u_sticky (
        .clock   (clock),
        .rst_n   (rst_n),
        .live    ({live_cal, live_lolhold, live_inalm, live_fault}),
        .lane_we (wr_stk),
        .wdata   (reg_req.wdata),
        .flags   (sticky)
    );

    // ======================================================
    // Alarm masks and the combined alarm
    logic [31:0] mask;
    logic [31:0] next_mask;
    logic [31:0] mask_valid;
    logic        next_alarm;

    assign mask_valid = {`CCS_CAL_VALID, `CCS_LOLHOLD_VALID,
                         `CCS_INALM_VALID, `CCS_FLT_MSK_VALID};
    for (genvar i = 0; i < 4; i++) begin : g_mask
        assign next_mask[i*8 +: 8] = wr_msk[i] ?
            (reg_req.wdata & mask_valid[i*8 +: 8]) : mask[i*8 +: 8];
    end
    // Masked flags stay readable, they just stop driving the alarm
    assign next_alarm = |(sticky & ~mask);

    // ======================================================
    // Read multiplexer, shared by host reads and burn capture
    function automatic logic [7:0] read_byte(input logic [7:0] ofs);
        logic [7:0] val;
        val = 8'h00;
        if (ofs == `CCS_OFS_PAGE) begin
            val = page_select;
        end else if (page0) begin
            case (ofs)
                `CCS_OFS_PN_LO:       val = PART_NUMBER[7:0];
                `CCS_OFS_PN_HI:       val = PART_NUMBER[15:8];
                `CCS_OFS_GRADE:       val = GRADE_CODE;
                `CCS_OFS_REV:         val = REV_CODE;
                `CCS_OFS_TOOL0:       val = tool_version[7:0];
                `CCS_OFS_TOOL1:       val = tool_version[15:8];
                `CCS_OFS_TOOL2:       val = tool_version[23:16];
                `CCS_OFS_TEMP:        val = TEMP_CODE;
                `CCS_OFS_PKG:         val = PKG_CODE;
                `CCS_OFS_ADDR:        val = {1'b0, serial_bus_address};
                `CCS_OFS_FLT:         val = live_fault;
                `CCS_OFS_INALM:       val = live_inalm;
                `CCS_OFS_LOLHOLD:     val = live_lolhold;
                `CCS_OFS_CAL:         val = live_cal;
                `CCS_OFS_FLT_STK:     val = sticky[7:0];
                `CCS_OFS_INALM_STK:   val = sticky[15:8];
                `CCS_OFS_LOLHOLD_STK: val = sticky[23:16];
                `CCS_OFS_CAL_STK:     val = sticky[31:24];
                `CCS_OFS_FLT_MSK:     val = mask[7:0];
                `CCS_OFS_INALM_MSK:   val = mask[15:8];
                `CCS_OFS_LOLHOLD_MSK: val = mask[23:16];
                `CCS_OFS_CAL_MSK:     val = mask[31:24];
                default:              val = 8'h00;
            endcase
        end
        return val;
    endfunction

    // ======================================================
    // Burn image: configuration only, never the bus address
    logic burnable;
    logic [7:0] next_nvm;

    assign burnable = (nvm_addr >= `CCS_OFS_TOOL0 &&
                       nvm_addr <= `CCS_OFS_TOOL2) ||
                      (nvm_addr >= `CCS_OFS_FLT_MSK &&
                       nvm_addr <= `CCS_OFS_CAL_MSK);
    // Address stays out so a burnt part can share a board
    // Procedural so the mux follows every register it reads
    always_comb begin
        next_nvm = 8'h00;
        if (burnable && nvm_addr != `CCS_OFS_ADDR) begin
            next_nvm = read_byte(nvm_addr);
        end
    end

    // ======================================================
    // Storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            page_select <= `CCS_PAGE_RST;
        end else if (wr_page) begin
            page_select <= reg_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tool_version <= `CCS_TOOL_RST;
        end else begin
            if (wr_tool0) tool_version[7:0]   <= reg_req.wdata;
            if (wr_tool1) tool_version[15:8]  <= reg_req.wdata;
            if (wr_tool2) tool_version[23:16] <= reg_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_bus_address <= `CCS_ADDR_RST;
        end else if (wr_addr) begin
            serial_bus_address <= reg_req.wdata[6:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask <= {`CCS_MSK_RST, `CCS_MSK_RST, `CCS_MSK_RST,
                     `CCS_FLT_MSK_RST};
        end else begin
            mask <= next_mask;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data     <= 8'h00;
            rd_valid    <= 1'b0;
            fault_alarm <= 1'b0;
            nvm_data    <= 8'h00;
        end else begin
            rd_data     <= reg_req.rd ? read_byte(reg_req.addr) : 8'h00;
            rd_valid    <= reg_req.rd;
            fault_alarm <= next_alarm;
            nvm_data    <= next_nvm;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_page_write_takes: assert property (
        (reg_req.wr && reg_req.addr == `CCS_OFS_PAGE) |=>
            page_select == $past(reg_req.wdata))
        else $error("page select did not take written value");
    a_page_read_back: assert property (
        (reg_req.rd && reg_req.addr == `CCS_OFS_PAGE) |=>
            (rd_valid && rd_data == $past(page_select)))
        else $error("page select read back wrong");
    a_part_number_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_PN_HI) |=>
            rd_data == PART_NUMBER[15:8])
        else $error("part number high byte wrong");
    a_grade_code_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_GRADE) |=>
            rd_data == GRADE_CODE)
        else $error("grade code read wrong");
    a_tool_major_write: assert property (
        wr_tool2 |=> tool_version.major == $past(reg_req.wdata[4:1]))
        else $error("tool major field misplaced");
    a_addr_not_burnt: assert property (
        nvm_addr == `CCS_OFS_ADDR |=> nvm_data == 8'h00)
        else $error("bus address leaked into burn image");
    a_timeout_gated_i2c: assert property (
        !i2c_mode |-> !live_fault[`CCS_FLT_TMOUT_BIT])
        else $error("timeout raised outside I2C mode");
    a_fault_reserved_zero: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_FLT_STK) |=>
            rd_data[7:6] == 2'h0 && rd_data[4] == 1'b0)
        else $error("reserved sticky bits not zero");
    a_input_flag_follows: assert property (
        status_sync.in_sig_missing[0] |=> sticky[8])
        else $error("input loss did not set sticky flag");
    a_alarm_mask_gate: assert property (
        (sticky == $past(sticky) && mask == $past(mask)) |=>
            fault_alarm == $past(|(sticky & ~mask)))
        else $error("alarm not gated by mask");
    a_part_low_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_PN_LO) |=>
            rd_data == PART_NUMBER[7:0])
        else $error("part number low byte wrong");
    a_rev_code_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_REV) |=>
            rd_data == REV_CODE)
        else $error("revision code read wrong");
    a_addr_write_takes: assert property (
        wr_addr |=> serial_bus_address == $past(reg_req.wdata[6:0]))
        else $error("bus address did not take written value");
    a_tool_burn_image: assert property (
        (nvm_addr == `CCS_OFS_TOOL0 && page0) |=>
            nvm_data == $past({tool_version.revision, tool_version.special}))
        else $error("tool version missing from burn image");
    a_other_page_zero: assert property (
        (reg_req.rd && !page0 && reg_req.addr != `CCS_OFS_PAGE) |=>
            rd_data == 8'h00)
        else $error("read on another page not zero");
    a_no_write_off_page: assert property (
        (reg_req.wr && !page0) |=> tool_version == $past(tool_version))
        else $error("write landed while another page was selected");

    // ======================================================
    // Checks on live status, sticky flags and idle read data
    a_live_fault_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_FLT) |=>
            rd_data[3:0] == $past({status_sync.xtal_lock_fault,
                status_sync.ref_missing, status_sync.xtal_nosig,
                status_sync.dev_cal}))
        else $error("live fault bits read wrong");
    a_input_live_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_INALM) |=>
            rd_data == $past({status_sync.in_freq_off,
                status_sync.in_sig_missing}))
        else $error("input alarm bits read wrong");
    a_pll_live_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_LOLHOLD) |=>
            (rd_data[1:0] == $past(status_sync.pll_unlocked) &&
             rd_data[5:4] == $past(status_sync.pll_holdover)))
        else $error("PLL lock and holdover read wrong");
    a_cal_live_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_CAL) |=>
            rd_data == {2'h0, $past(status_sync.pll_cal_busy), 4'h0})
        else $error("PLL calibration bits read wrong");
    a_timeout_flag_sets: assert property (
        live_fault[`CCS_FLT_TMOUT_BIT] |=> sticky[`CCS_FLT_TMOUT_BIT])
        else $error("bus timeout did not set sticky flag");
    a_pll_flag_follows: assert property (
        status_sync.pll_unlocked[1] |=> sticky[17])
        else $error("PLL unlock did not set sticky flag");
    a_input_sticky_read: assert property (
        (reg_req.rd && page0 && reg_req.addr == `CCS_OFS_INALM_STK) |=>
            rd_data == $past(sticky[15:8]))
        else $error("input sticky flags read wrong");
    a_pll_reserved_zero: assert property (
        (reg_req.rd && reg_req.addr == `CCS_OFS_LOLHOLD) |=>
            (rd_data[7:6] == 2'h0 && rd_data[3:2] == 2'h0))
        else $error("reserved PLL status bits not zero");
    a_read_idle_zero: assert property (
        !reg_req.rd |=> (!rd_valid && rd_data == 8'h00))
        else $error("read data left standing without a request");
endmodule // ccs_regs

// >>> sim/ccs_host.sv
/*
 Host model on the register port: byte writes and reads.
 Assumes requests start only after reset has been released.
*/
module ccs_host
    import ccs_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Register access
    output ccs_req_type      reg_req,
    input  wire logic [7:0]  rd_data,
    input  wire logic        rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    initial reg_req = '0;

    // ==========================================================
    // One-cycle request, held across the taking edge
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_req.wr    = 1'b1;
        reg_req.addr  = a;
        reg_req.wdata = d;
        @(posedge clock);
        #1;
        reg_req.wr    = 1'b0;
        reg_req.wdata = ~d;
    endtask

    // Answer stands one cycle only, so it is taken right away
    task automatic read(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
        @(posedge clock);
        #1;
        reg_req.rd   = 1'b1;
        reg_req.addr = a;
        @(posedge clock);
        #1;
        reg_req.rd   = 1'b0;
        d = rd_data;
        v = rd_valid;
    endtask
endmodule // ccs_host

// >>> sim/tb.sv
/*
 Self-checking bench of the page-0 status and identity bank.
 Assumes the host model drives the register port.
*/
module tb
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals
    logic                 clock;
    logic                 rst_n;
    ccs_req_type          reg_req;
    logic [7:0]           rd_data;
    logic                 rd_valid;
    ccs_status_type       status_raw;
    logic                 i2c_mode;
    logic [7:0]           page_select;
    logic [6:0]           serial_bus_address;
    ccs_tool_version_type tool_version;
    logic                 fault_alarm;
    logic [7:0]           nvm_addr;
    logic [7:0]           nvm_data;
    int                   num_errors;
    int                   n_compared;
    logic [7:0]           fb [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};

    ccs_regs ccs_regs_i (
        .clock(clock), .rst_n(rst_n), .reg_req(reg_req),
        .rd_data(rd_data), .rd_valid(rd_valid), .status_raw(status_raw),
        .i2c_mode(i2c_mode), .page_select(page_select),
        .serial_bus_address(serial_bus_address),
        .tool_version(tool_version), .fault_alarm(fault_alarm),
        .nvm_addr(nvm_addr), .nvm_data(nvm_data)
    );

    ccs_host ccs_host_i (
        .clock(clock), .reg_req(reg_req), .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    always #50 clock = ~clock;

    // ==========================================================
    // Checks and access helpers
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        ccs_host_i.read(a, d, v);
        chk({23'h0, v}, 24'h1);
        chk({16'h0, d}, {16'h0, e});
    endtask

    // Live levels wait out the two-flop sync and the sticky stage
    task automatic set_flt(input logic [7:0] f);
        @(posedge clock);
        #1;
        status_raw.dev_cal         = f[0];
        status_raw.xtal_nosig      = f[1];
        status_raw.ref_missing     = f[2];
        status_raw.xtal_lock_fault = f[3];
        status_raw.bus_timeout     = f[5];
        repeat (6) @(posedge clock);
        #1;
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #(5000 * 100);
        num_errors++;
        stop_test();
    end

    // ==========================================================
    // Tests
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        status_raw = '0;
        i2c_mode = 1'b1;
        nvm_addr = 8'h00;
        num_errors = 0;
        n_compared = 0;
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;

        chk({16'h0, page_select}, 24'h0);
        rd_chk(8'h0B, 8'h68);
        rd_chk(8'h17, 8'hC0);
        rd_chk(8'h18, 8'h00);
        rd_chk(8'h02, 8'h34);
        rd_chk(8'h03, 8'h12);
        ccs_host_i.write(8'h04, 8'h55);
        rd_chk(8'h04, 8'h00);
        rd_chk(8'h05, 8'h00);
        $display("identity test done");

        ccs_host_i.write(8'h06, 8'hA5);
        ccs_host_i.write(8'h07, 8'h3C);
        ccs_host_i.write(8'h08, 8'hE3);
        rd_chk(8'h08, 8'hE3);
        chk(tool_version, {3'h7, 4'h1, 9'h13C, 4'hA, 4'h5});
        ccs_host_i.write(8'h0B, 8'hFF);
        rd_chk(8'h0B, 8'h7F);
        chk({17'h0, serial_bus_address}, 24'h7F);
        @(posedge clock);
        #1;
        nvm_addr = 8'h0B;
        @(posedge clock);
        #1;
        chk({16'h0, nvm_data}, 24'h0);
        nvm_addr = 8'h06;
        @(posedge clock);
        #1;
        chk({16'h0, nvm_data}, 24'hA5);
        $display("config test done");

        ccs_host_i.write(8'h01, 8'hFF);
        chk({16'h0, page_select}, 24'hFF);
        rd_chk(8'h01, 8'hFF);
        rd_chk(8'h04, 8'h00);
        ccs_host_i.write(8'h01, 8'h00);
        rd_chk(8'h01, 8'h00);
        $display("page test done");

        foreach (fb[k]) begin
            set_flt(fb[k]);
            rd_chk(8'h0C, fb[k]);
            ccs_host_i.write(8'h11, 8'h00);
            rd_chk(8'h11, fb[k]);
            set_flt(8'h00);
            rd_chk(8'h0C, 8'h00);
            rd_chk(8'h11, fb[k]);
            chk({23'h0, fault_alarm}, 24'h1);
            ccs_host_i.write(8'h11, 8'hFF);
            rd_chk(8'h11, fb[k]);
            ccs_host_i.write(8'h11, 8'h00);
            rd_chk(8'h11, 8'h00);
        end
        i2c_mode = 1'b0;
        set_flt(8'h20);
        rd_chk(8'h0C, 8'h00);
        rd_chk(8'h11, 8'h00);
        set_flt(8'h00);
        i2c_mode = 1'b1;
        $display("fault test done");

        status_raw.in_sig_missing = 4'h1;
        status_raw.in_freq_off    = 4'h8;
        repeat (6) @(posedge clock);
        rd_chk(8'h0D, 8'h81);
        status_raw.in_freq_off = 4'h0;
        repeat (6) @(posedge clock);
        rd_chk(8'h0D, 8'h01);
        rd_chk(8'h12, 8'h81);
        chk({23'h0, fault_alarm}, 24'h1);
        ccs_host_i.write(8'h18, 8'hFF);
        repeat (3) @(posedge clock);
        #1;
        chk({23'h0, fault_alarm}, 24'h0);
        ccs_host_i.write(8'h12, 8'h00);
        rd_chk(8'h12, 8'h01);
        $display("input alarm test done");

        status_raw.pll_unlocked = 2'b10;
        status_raw.pll_holdover = 2'b01;
        status_raw.pll_cal_busy = 2'b01;
        repeat (6) @(posedge clock);
        rd_chk(8'h0E, 8'h12);
        rd_chk(8'h0F, 8'h10);
        status_raw.pll_unlocked = 2'b00;
        status_raw.pll_holdover = 2'b00;
        repeat (6) @(posedge clock);
        rd_chk(8'h0E, 8'h00);
        rd_chk(8'h13, 8'h12);
        rd_chk(8'h10, 8'h00);
        ccs_host_i.write(8'h13, 8'hFF);
        rd_chk(8'h13, 8'h12);
        $display("pll test done");
        stop_test();
    end
endmodule // tb
